//--- verilog/ssce_pkg.sv
// Shared constants for the slave command decoder and its host
package ssce_pkg;
	// Command code byte fields
	localparam int FN_LSB = 2;
	localparam logic [2:0] FN_CSR = 3'h0;
	localparam logic [2:0] FN_EE = 3'h1;
	localparam int SZ_LSB = 5;
	localparam logic [1:0] SZ_BLOCK = 2'h2;
	// CSR command byte bits
	localparam int CMD_OP = 4;
	localparam int CMD_RSV = 5;
	localparam int CMD_READ_UNCLAIMED_FLAG = 6;
	localparam int CMD_WRITE_UNCLAIMED_FLAG = 7;
	localparam int BE_W = 4;
	localparam int CSR_AW = 14;
	localparam int ADDRESS_HIGH_BYTE_W = 6;
	// EEPROM command byte bits
	localparam int EE_OP = 0;
	localparam int EE_USA = 1;
	// Byte positions in a transfer
	localparam logic [3:0] POS_COMMAND_CODE_BYTE = 4'h0;
	localparam logic [3:0] POS_CNT = 4'h1;
	localparam logic [3:0] POS_CMD = 4'h2;
	localparam logic [3:0] POS_ADL = 4'h3;
	localparam logic [3:0] POS_ADU = 4'h4;
	localparam logic [3:0] POS_D0 = 4'h5;
	localparam logic [3:0] POS_D1 = 4'h6;
	localparam logic [3:0] POS_D2 = 4'h7;
	localparam logic [3:0] POS_D3 = 4'h8;
	localparam logic [3:0] POS_EBA = 4'h3;
	localparam logic [3:0] POS_EAL = 4'h4;
	localparam logic [3:0] POS_EAH = 4'h5;
	localparam logic [3:0] POS_ED = 4'h6;
	localparam logic [3:0] CSR_LAST = 4'h8;
	localparam logic [3:0] EE_LAST = 4'h6;
	localparam logic [7:0] CNT_CSR = 8'h07;
	localparam logic [7:0] CNT_EE = 8'h05;
	localparam int NPOS = 9;
	// Host register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TX0 = 8'h04;
	localparam logic [7:0] REG_TX1 = 8'h08;
	localparam logic [7:0] REG_TX2 = 8'h0C;
	localparam logic [7:0] REG_RX0 = 8'h10;
	localparam logic [7:0] REG_RX1 = 8'h14;
	localparam logic [7:0] REG_RX2 = 8'h18;
	localparam logic [7:0] REG_STAT = 8'h1C;
	localparam logic [7:0] REG_MASK = 8'h20;
	// Host control and status bits
	localparam int CTRL_GO = 0;
	localparam int CTRL_RD = 1;
	localparam int CTRL_CNT_LSB = 8;
	localparam int ST_DONE = 0;
	localparam int ST_NACK = 1;
	localparam int ST_BUSY = 2;
	localparam int NEV = 2;
	localparam int TXB = 12;
endpackage

//--- verilog/ssce_link_if.sv
// Byte link between the command host and the slave decoder
`timescale 1ns/10ps
interface ssce_link_if (
	input wire logic i_clk
);
	logic req; // Host offers a byte or asks for one, one cycle
	logic req_rd; // Request is a read
	logic [7:0] req_byte; // Byte written by host
	logic req_last; // Last byte of a host write
	logic ans; // Device answers, one cycle
	logic ans_nack; // Request refused
	logic [7:0] ans_byte; // Byte returned on read
	logic ans_last; // Last byte of a device reply
	modport dev (input req, req_rd, req_byte, req_last, output ans, ans_nack, ans_byte, ans_last);
	modport host (output req, req_rd, req_byte, req_last, input ans, ans_nack, ans_byte, ans_last);
endinterface

//--- verilog/ssce_dev.sv
// Slave side payload decoder for CSR and EEPROM command transfers
`timescale 1ns/10ps
// Overview of operation
// - Data word travels low byte first
// - Command bits 3:0 enable data byte lanes
// - Command bit 4 picks write or read
// - Host drives reserved command bit 5 zero
// - Unclaimed read sets flag, read clears it
// - Unclaimed write sets flag, read clears it
// - Code at 0, count at 1 if block
// - Count gives following bytes, status included
// - Position 2 holds the EEPROM command
// - Position 3 holds left justified bus address
// - Positions 4,5 hold EEPROM byte address
// - Position 6 holds the EEPROM data byte
// - Upper address uses six bits, ignores two
// - Function field selects CSR or EEPROM form
// - NACK when busy or no data ready
// - Given bus address replaces configured one
module ssce_dev (
	input wire logic i_clk,
	input wire logic i_rst,
	ssce_link_if.dev link,
	output logic o_csr_req,
	output logic o_csr_rd,
	output logic [ssce_pkg::CSR_AW-1:0] o_csr_addr,
	output logic [ssce_pkg::BE_W-1:0] o_csr_be,
	output logic [31:0] o_csr_wdata,
	input wire logic i_csr_done,
	input wire logic i_csr_claimed,
	input wire logic [31:0] i_csr_rdata,
	output logic o_ee_req,
	output logic o_ee_rd,
	output logic [7:0] o_ee_bus_addr,
	output logic [15:0] o_ee_addr,
	output logic [7:0] o_ee_wdata,
	input wire logic [7:0] i_ee_cfg_addr,
	input wire logic i_ee_done,
	input wire logic [7:0] i_ee_rdata,
	output logic o_busy
);
	import ssce_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_WAIT
	} ssce_dev_st_t;

	ssce_dev_st_t st_q; // Execution state
	logic [7:0] rx_q [0:NPOS-1]; // Transfer bytes by position
	logic [3:0] wpos_q; // Next position written
	logic [3:0] rpos_q; // Next position returned
	logic resp_q; // A reply is ready
	logic rd_flag_q; // Read not claimed
	logic wr_flag_q; // Write not claimed
	logic ans_q; // Answer strobe
	logic nack_q; // Answer is a refusal
	logic [7:0] abyte_q; // Returned byte
	logic alast_q; // Returned byte is the last

	logic [7:0] command_code_byte; // Stored command code
	logic [7:0] cmd; // Stored command byte
	logic is_blk; // Block form with count byte
	logic is_ee; // EEPROM form
	logic is_csr; // CSR form
	logic op_rd; // Operation is a read
	logic [3:0] last_pos; // Final position of the form
	logic wr_req; // Host write request
	logic rd_req; // Host read request
	logic wr_ok; // Write byte accepted
	logic rd_ok; // Read served
	logic [3:0] wnext; // Position after the one written
	logic [3:0] rnext; // Position after the one returned
	logic [7:0] rbyte; // Byte at the read position
	logic done; // Target finished
	logic clr_flags; // Flags were read out
	logic set_rd; // Read went unclaimed
	logic set_wr; // Write went unclaimed

	// Decode of the stored header
	assign command_code_byte = rx_q[POS_COMMAND_CODE_BYTE];
	assign cmd = rx_q[POS_CMD];
	assign is_blk = command_code_byte[SZ_LSB+:2] == SZ_BLOCK;
	assign is_csr = command_code_byte[FN_LSB+:3] == FN_CSR;
	assign is_ee = command_code_byte[FN_LSB+:3] == FN_EE;
	assign op_rd = is_ee ? cmd[EE_OP] : cmd[CMD_OP];
	assign last_pos = is_ee ? EE_LAST : CSR_LAST;

	// Request qualification
	assign wr_req = link.req && !link.req_rd;
	assign rd_req = link.req && link.req_rd;
	assign wr_ok = wr_req && st_q == ST_IDLE;
	assign rd_ok = rd_req && st_q == ST_IDLE && resp_q;

	// Count byte is skipped outside block transfers
	always_comb begin
		if (wpos_q == POS_COMMAND_CODE_BYTE && link.req_byte[SZ_LSB+:2] != SZ_BLOCK) begin
			wnext = POS_CMD;
		end else begin
			wnext = 4'(wpos_q + 4'h1);
		end
		if (rpos_q == POS_COMMAND_CODE_BYTE && !is_blk) begin
			rnext = POS_CMD;
		end else begin
			rnext = 4'(rpos_q + 4'h1);
		end
	end

	// Reply byte for the current read position
	always_comb begin
		case (rpos_q)
			POS_CNT: begin
				rbyte = is_ee ? CNT_EE : CNT_CSR;
			end
			POS_CMD: begin
				if (is_csr) begin
					// Flags replace the host bits; reserved bit reads zero
					rbyte = {wr_flag_q, rd_flag_q, 1'b0, cmd[CMD_OP:0]};
				end else begin
					rbyte = cmd;
				end
			end
			default: begin
				rbyte = rx_q[rpos_q];
			end
		endcase
	end

	assign clr_flags = rd_ok && rpos_q == POS_CMD && is_csr;
	assign done = is_ee ? i_ee_done : i_csr_done;
	assign set_rd = st_q == ST_WAIT && is_csr && i_csr_done && op_rd && !i_csr_claimed;
	assign set_wr = st_q == ST_WAIT && is_csr && i_csr_done && !op_rd && !i_csr_claimed;

	// Execution sequence
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					// Whole command taken, go act on it
					if (wr_ok && link.req_last) begin
						st_q <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					// Reserved functions are dropped
					st_q <= (is_csr || is_ee) ? ST_WAIT : ST_IDLE;
				end
				ST_WAIT: begin
					if (done) begin
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Write position counter
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wpos_q <= POS_COMMAND_CODE_BYTE;
		end else if (wr_ok) begin
			wpos_q <= link.req_last ? POS_COMMAND_CODE_BYTE : wnext;
		end
	end

	// Transfer byte store, filled by host and by target reads
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < NPOS; i++) begin
				rx_q[i] <= 8'h00;
			end
		end else if (wr_ok && wpos_q < 4'(NPOS)) begin
			rx_q[wpos_q] <= link.req_byte;
		end else if (st_q == ST_WAIT && is_csr && i_csr_done && op_rd && i_csr_claimed) begin
			rx_q[POS_D0] <= i_csr_rdata[7:0];
			rx_q[POS_D1] <= i_csr_rdata[15:8];
			rx_q[POS_D2] <= i_csr_rdata[23:16];
			rx_q[POS_D3] <= i_csr_rdata[31:24];
		end else if (st_q == ST_WAIT && is_ee && i_ee_done && op_rd) begin
			rx_q[POS_ED] <= i_ee_rdata;
		end
	end

	// Reply availability and read position
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			resp_q <= 1'b0;
			rpos_q <= POS_COMMAND_CODE_BYTE;
		end else if (wr_ok) begin
			// A new command withdraws the old reply
			resp_q <= 1'b0;
			rpos_q <= POS_COMMAND_CODE_BYTE;
		end else if (st_q == ST_WAIT && done) begin
			resp_q <= 1'b1;
		end else if (rd_ok) begin
			resp_q <= rpos_q != last_pos;
			rpos_q <= rpos_q == last_pos ? POS_COMMAND_CODE_BYTE : rnext;
		end
	end

	// Sticky unclaimed flags; a new event wins over the clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_flag_q <= 1'b0;
			wr_flag_q <= 1'b0;
		end else begin
			rd_flag_q <= (rd_flag_q && !clr_flags) || set_rd;
			wr_flag_q <= (wr_flag_q && !clr_flags) || set_wr;
		end
	end

	// Link answer, one cycle after each request
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ans_q <= 1'b0;
			nack_q <= 1'b0;
			abyte_q <= 8'h00;
			alast_q <= 1'b0;
		end else begin
			ans_q <= link.req;
			nack_q <= link.req && !(wr_ok || rd_ok);
			abyte_q <= rd_ok ? rbyte : 8'h00;
			alast_q <= rd_ok && rpos_q == last_pos;
		end
	end

	assign link.ans = ans_q;
	assign link.ans_nack = nack_q;
	assign link.ans_byte = abyte_q;
	assign link.ans_last = alast_q;

	// CSR target request, built from stored bytes
	assign o_csr_req = st_q == ST_ISSUE && is_csr;
	assign o_csr_rd = cmd[CMD_OP];
	assign o_csr_addr = {rx_q[POS_ADU][ADDRESS_HIGH_BYTE_W-1:0], rx_q[POS_ADL]};
	assign o_csr_be = cmd[BE_W-1:0];
	assign o_csr_wdata = {rx_q[POS_D3], rx_q[POS_D2], rx_q[POS_D1], rx_q[POS_D0]};

	// EEPROM engine request
	assign o_ee_req = st_q == ST_ISSUE && is_ee;
	assign o_ee_rd = cmd[EE_OP];
	assign o_ee_bus_addr = cmd[EE_USA] ? rx_q[POS_EBA] : i_ee_cfg_addr;
	assign o_ee_addr = {rx_q[POS_EAH], rx_q[POS_EAL]};
	assign o_ee_wdata = rx_q[POS_ED];

	assign o_busy = st_q != ST_IDLE;
endmodule

//--- verilog/ssce_host.sv
// Command host: sends and fetches payload bytes on software order
`timescale 1ns/10ps
module ssce_host (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	ssce_link_if.host link
);
	import ssce_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE,
		H_REQ,
		H_WAIT
	} ssce_host_st_t;

	ssce_host_st_t st_q; // Engine state
	logic rd_q; // Transfer is a read
	logic [3:0] cnt_q; // Bytes in transfer
	logic [3:0] idx_q; // Current byte
	logic [TXB*8-1:0] tx_q; // Bytes to send
	logic [TXB*8-1:0] rx_q; // Bytes received
	logic [NEV-1:0] stat_q; // Sticky events
	logic [NEV-1:0] mask_q; // Event enables
	logic acc; // APB access phase
	logic wr; // APB write
	logic hit; // Mapped address
	logic go; // Start order
	logic fin; // Byte was the last
	logic [NEV-1:0] ev; // Events this cycle
	logic [NEV-1:0] clr; // Write-one-clear

	assign acc = i_psel && i_penable;
	assign wr = acc && i_pwrite;
	assign go = wr && i_paddr == REG_CTRL && i_pwdata[CTRL_GO] && st_q == H_IDLE
		&& i_pwdata[CTRL_CNT_LSB+:4] != 4'h0;
	assign fin = rd_q ? (link.ans_last || idx_q == 4'(cnt_q - 4'h1)) : idx_q == 4'(cnt_q - 4'h1);
	assign ev[ST_DONE] = st_q == H_WAIT && link.ans && !link.ans_nack && fin;
	assign ev[ST_NACK] = st_q == H_WAIT && link.ans && link.ans_nack;
	assign clr = (wr && i_paddr == REG_STAT) ? i_pwdata[NEV-1:0] : '0;

	// Transfer engine, one request outstanding at a time
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= H_IDLE;
			idx_q <= 4'h0;
		end else begin
			case (st_q)
				H_IDLE: begin
					if (go) begin
						st_q <= H_REQ;
						idx_q <= 4'h0;
					end
				end
				H_REQ: begin
					st_q <= H_WAIT;
				end
				H_WAIT: begin
					// Refusal or last byte ends the transfer
					if (link.ans) begin
						if (link.ans_nack || fin) begin
							st_q <= H_IDLE;
						end else begin
							st_q <= H_REQ;
							idx_q <= 4'(idx_q + 4'h1);
						end
					end
				end
				default: begin
					st_q <= H_IDLE;
				end
			endcase
		end
	end

	// Control and transmit registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_q <= 1'b0;
			cnt_q <= 4'h0;
			tx_q <= '0;
		end else begin
			if (go) begin
				rd_q <= i_pwdata[CTRL_RD];
				cnt_q <= i_pwdata[CTRL_CNT_LSB+:4];
			end
			if (wr && i_paddr == REG_TX0) begin
				tx_q[31:0] <= i_pwdata;
			end
			if (wr && i_paddr == REG_TX1) begin
				tx_q[63:32] <= i_pwdata;
			end
			if (wr && i_paddr == REG_TX2) begin
				tx_q[95:64] <= i_pwdata;
			end
		end
	end

	// Received bytes, low byte of word 0 first
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_q <= '0;
		end else if (st_q == H_WAIT && link.ans && !link.ans_nack && rd_q) begin
			rx_q[{idx_q, 3'h0}+:8] <= link.ans_byte;
		end
	end

	// Sticky status, set wins over clear; and the mask
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			stat_q <= '0;
			mask_q <= '0;
		end else begin
			stat_q <= (stat_q & ~clr) | ev;
			if (wr && i_paddr == REG_MASK) begin
				mask_q <= i_pwdata[NEV-1:0];
			end
		end
	end

	// Read mux
	always_comb begin
		hit = 1'b1;
		o_prdata = 32'h0000_0000;
		case (i_paddr)
			REG_CTRL: o_prdata = {20'h0_0000, cnt_q, 6'h00, rd_q, 1'b0};
			REG_TX0: o_prdata = tx_q[31:0];
			REG_TX1: o_prdata = tx_q[63:32];
			REG_TX2: o_prdata = tx_q[95:64];
			REG_RX0: o_prdata = rx_q[31:0];
			REG_RX1: o_prdata = rx_q[63:32];
			REG_RX2: o_prdata = rx_q[95:64];
			REG_STAT: o_prdata = {29'h0000_0000, st_q != H_IDLE, stat_q};
			REG_MASK: o_prdata = {30'h0000_0000, mask_q};
			default: hit = 1'b0;
		endcase
	end

	assign o_pready = acc;
	assign o_pslverr = acc && !hit;
	assign o_irq = |(stat_q & mask_q);

	// Link request from engine state
	assign link.req = st_q == H_REQ;
	assign link.req_rd = rd_q;
	assign link.req_byte = tx_q[{idx_q, 3'h0}+:8];
	assign link.req_last = !rd_q && idx_q == 4'(cnt_q - 4'h1);
endmodule

//--- verification/ssce_link_monitor.sv
// Protocol checks on the byte link between host and decoder
`timescale 1ns/10ps
module ssce_link_monitor (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_req_rd,
	input wire logic [7:0] i_req_byte,
	input wire logic i_req_last,
	input wire logic i_ans,
	input wire logic i_ans_nack,
	input wire logic [7:0] i_ans_byte,
	input wire logic i_ans_last
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// One request, then its answer with the direction held
	sequence s_req;
		i_req;
	endsequence
	sequence s_ans;
		i_ans ##0 $stable(i_req_rd);
	endsequence
	a_ans_one_later: assert property (s_req |=> s_ans) else $error("no answer one cycle after request");
	a_no_stray_ans: assert property (i_ans |-> $past(i_req)) else $error("answer without request");
	a_req_spaced: assert property (i_req |=> !i_req) else $error("request in answer cycle");
	a_idle_byte_zero: assert property (!i_ans |-> i_ans_byte == 8'h00) else $error("reply byte outside answer");
	a_write_byte_zero: assert property (i_ans && !$past(i_req_rd) |-> i_ans_byte == 8'h00)
		else $error("byte on write answer");
	a_last_with_ans: assert property (i_ans_last |-> i_ans && !i_ans_nack)
		else $error("last flag without good answer");
	a_last_read_only: assert property (i_ans_last |-> $past(i_req_rd)) else $error("last flag on write answer");
	a_final_is_write: assert property (i_req && i_req_last |-> !i_req_rd) else $error("final flag on read");
endmodule

//--- verification/tb.sv
// Testbench joining host and decoder over the byte link
`timescale 1ns/10ps
module tb;
	import ssce_pkg::*;
	typedef struct packed {logic [71:0] p; logic clm; logic [31:0] rd;} ssce_row_t;
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, clm = 1'h0, csr_done = 1'h0, ee_done = 1'h0;
	logic [7:0] padr = 8'h00, cfg = 8'h50, ee_rdata = 8'h00, ee_wdata, bus, cmd, c_b;
	logic [31:0] pwd = 32'h0, csr_rdata = 32'h0, prdata, wd, r, st, c_w;
	logic pready, pslverr, irq, csr_req, csr_rd, ee_req, ee_rd, busy, e, c_ee, c_rd, blk, ee;
	logic [13:0] caddr;
	logic [3:0] be, c_be, n, rl;
	logic [15:0] eaddr, c_a;
	logic [71:0] p, q, eq;
	logic [95:0] tx, g, m;
	int miscompares = 0, num_checks = 0, nreq = 0, dly = 0, k;
	// Positions 8..0 packed, claim, read data
	ssce_row_t rows [6] = '{
		'{72'h44_33_22_11_C5_34_0F_07_40, 1'h1, 32'h0}, // Command bit 5 held zero in every row
		'{72'h88_77_66_55_01_20_05_07_40, 1'h0, 32'h0},
		'{72'h00_00_00_00_02_10_1A_07_40, 1'h1, 32'hA1B2C3D4},
		'{72'h00_00_00_00_03_11_13_07_40, 1'h0, 32'h0},
		'{72'h00_00_5A_BE_EF_A6_02_05_44, 1'h1, 32'h0}, // Bus address left justified, bit 0 zero
		'{72'h00_00_00_34_12_00_01_00_04, 1'h1, 32'h77}};
	initial forever #20 clk = ~clk;
	ssce_link_if u_ssce_link_if (.i_clk(clk));
	ssce_dev u_ssce_dev (.i_clk(clk), .i_rst(rst), .link(u_ssce_link_if.dev), .o_csr_req(csr_req),
		.o_csr_rd(csr_rd), .o_csr_addr(caddr), .o_csr_be(be), .o_csr_wdata(wd), .i_csr_done(csr_done),
		.i_csr_claimed(clm), .i_csr_rdata(csr_rdata), .o_ee_req(ee_req), .o_ee_rd(ee_rd),
		.o_ee_bus_addr(bus), .o_ee_addr(eaddr), .o_ee_wdata(ee_wdata), .i_ee_cfg_addr(cfg),
		.i_ee_done(ee_done), .i_ee_rdata(ee_rdata), .o_busy(busy));
	ssce_host u_ssce_host (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(padr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_irq(irq), .link(u_ssce_link_if.host));
	ssce_link_monitor u_ssce_link_monitor (.i_clk(clk), .i_rst(rst), .i_req(u_ssce_link_if.req),
		.i_req_rd(u_ssce_link_if.req_rd), .i_req_byte(u_ssce_link_if.req_byte),
		.i_req_last(u_ssce_link_if.req_last), .i_ans(u_ssce_link_if.ans), .i_ans_nack(u_ssce_link_if.ans_nack),
		.i_ans_byte(u_ssce_link_if.ans_byte), .i_ans_last(u_ssce_link_if.ans_last));
	// Target: records each request, answers after dly extra cycles
	initial forever begin
		@(negedge clk);
		if (csr_req === 1'h1 || ee_req === 1'h1) begin
			nreq++;
			c_ee = ee_req;
			c_rd = c_ee ? ee_rd : csr_rd;
			c_a = c_ee ? eaddr : {2'h0, caddr};
			c_w = c_ee ? {24'h0, ee_wdata} : wd;
			c_b = c_ee ? bus : 8'h00;
			c_be = c_ee ? 4'h0 : be;
			@(posedge clk);
			repeat (dly) @(posedge clk);
			csr_done <= !c_ee;
			ee_done <= c_ee;
			@(posedge clk);
			csr_done <= 1'h0;
			ee_done <= 1'h0;
		end
	end
	task chk(input string s, input logic [95:0] x, input logic [95:0] y);
		num_checks++;
		if (x !== y) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", s, x, y);
		end
	endtask
	// One APB transfer; holds until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask
	// Polls status until done or refused
	task hwait;
		int t;
		t = 0;
		st = 0;
		while (st[1:0] === 2'h0 && t < 100) begin
			apb(1'h0, REG_STAT, 32'h0);
			st = r;
			t++;
		end
		chk("host finish", 1, t < 100);
	endtask
	task xfer(input logic [95:0] b, input logic [3:0] c, input logic rd);
		apb(1'h1, REG_TX0, b[31:0]);
		apb(1'h1, REG_TX1, b[63:32]);
		apb(1'h1, REG_TX2, b[95:64]);
		apb(1'h1, REG_CTRL, {20'h0, c, 6'h0, rd, 1'h1});
		hwait;
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#400000;
		miscompares++;
		test_done;
	end
	initial begin
		repeat (11) @(posedge clk);
		@(negedge clk);
		chk("reset outputs", 3'h0, {busy, irq, u_ssce_link_if.ans});
		@(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		foreach (rows[i]) begin
			p = rows[i].p;
			blk = p[6:5] == SZ_BLOCK;
			ee = p[4:2] == FN_EE;
			cmd = p[23:16];
			tx = blk ? {24'h0, p} : {32'h0, p[71:16], p[7:0]};
			clm <= rows[i].clm;
			csr_rdata <= rows[i].rd;
			ee_rdata <= rows[i].rd[7:0];
			rl = (ee ? 4'h7 : 4'h9) - {3'h0, !blk};
			k = nreq;
			xfer(tx, rl, 1'h0);
			apb(1'h1, REG_STAT, 32'h3);
			chk("target request", k + 1, nreq);
			chk("target form", ee, c_ee);
			chk("target read", ee ? cmd[EE_OP] : cmd[CMD_OP], c_rd);
			chk("target addr", ee ? p[47:32] : {2'h0, p[37:32], p[31:24]}, c_a);
			chk("target data", ee ? p[55:48] : p[71:40], c_w);
			chk("target lanes", ee ? 4'h0 : cmd[3:0], c_be);
			chk("bus address", ee ? (cmd[EE_USA] ? p[31:24] : cfg) : 8'h00, c_b);
			q = p;
			q[23:16] = ee ? cmd : {!rows[i].clm & !cmd[4], !rows[i].clm & cmd[4], 1'h0, cmd[4:0]};
			if (blk) q[15:8] = ee ? CNT_EE : CNT_CSR;
			if (!ee && cmd[4] && rows[i].clm) q[71:40] = rows[i].rd;
			if (ee && cmd[0]) q[55:48] = rows[i].rd[7:0];
			eq = blk ? q : {8'h0, q[71:16], q[7:0]};
			m = (96'h1 << {rl, 3'h0}) - 96'h1;
			xfer(96'h0, rl, 1'h1);
			apb(1'h1, REG_STAT, 32'h3);
			apb(1'h0, REG_RX0, 32'h0);
			g[31:0] = r;
			apb(1'h0, REG_RX1, 32'h0);
			g[63:32] = r;
			apb(1'h0, REG_RX2, 32'h0);
			g[95:64] = r;
			chk("reply bytes", eq & m, g & m);
			$display("row %0d finished", i);
		end
		// Reserved function code is dropped without a target request
		k = nreq;
		xfer({24'h0, 72'h0, 8'h48}, 4'h9, 1'h0);
		apb(1'h1, REG_STAT, 32'h3);
		repeat (10) @(posedge clk);
		chk("reserved form", k, nreq);
		// A read with no reply ready is refused
		xfer(96'h0, 4'h1, 1'h1);
		chk("read without reply", 1'h1, st[ST_NACK]);
		apb(1'h1, REG_STAT, 32'h3);
		$display("reserved form finished");
		// Second command while the first still waits on its target
		dly = 40;
		xfer({24'h0, rows[0].p}, 4'h9, 1'h0);
		apb(1'h1, REG_STAT, 32'h3);
		apb(1'h1, REG_CTRL, 32'h901);
		hwait;
		chk("busy refusal", 1'h1, st[ST_NACK]);
		// Interrupt follows the masked sticky status
		apb(1'h1, REG_MASK, 32'h0);
		chk("irq masked", 1'h0, irq);
		apb(1'h1, REG_MASK, 32'h2);
		chk("irq raised", 1'h1, irq);
		apb(1'h1, REG_STAT, 32'h3);
		chk("irq cleared", 1'h0, irq);
		dly = 0;
		k = 0;
		while (busy !== 1'h0 && k < 100) begin
			@(posedge clk);
			k++;
		end
		chk("decoder idle", 1'h0, busy);
		$display("busy and interrupt finished");
		// Unmapped address is refused
		apb(1'h0, 8'h40, 32'h0);
		chk("unmapped error", 1'h1, e);
		chk("unmapped data", 32'h0, r);
		$display("unmapped access finished");
		// Mid-run reset drops status, mask and any pending reply
		clm <= 1'h0;
		apb(1'h1, REG_MASK, 32'h3);
		xfer({24'h0, rows[1].p}, 4'h9, 1'h0);
		chk("irq before reset", 1'h1, irq);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		@(negedge clk);
		chk("outputs after reset", 3'h0, {busy, irq, u_ssce_link_if.ans});
		@(posedge clk);
		apb(1'h0, REG_MASK, 32'h0);
		chk("mask after reset", 32'h0, r);
		xfer(96'h0, 4'h1, 1'h1);
		chk("no reply after reset", 1'h1, st[ST_NACK]);
		$display("mid-run reset finished");
		test_done;
	end
endmodule
